/* verilog/dcpr_consts.svh */
`ifndef DCPR_CONSTS_SVH
`define DCPR_CONSTS_SVH
// ==========================================
// i/o port map, low byte of the port number
`define DCPR_IO_HI 8'h00
`define DCPR_ADR_P0 8'h00
`define DCPR_ADR_P1 8'h02
`define DCPR_ADR_P2 8'h04
`define DCPR_ADR_P3 8'h06
`define DCPR_ADR_P4 8'hc0
`define DCPR_ADR_P5 8'hc4
`define DCPR_ADR_P6 8'hc8
`define DCPR_ADR_P7 8'hcc
`define DCPR_CNT_P0 8'h01
`define DCPR_CNT_P1 8'h03
`define DCPR_CNT_P2 8'h05
`define DCPR_CNT_P3 8'h07
`define DCPR_CNT_P4 8'hc2
`define DCPR_CNT_P5 8'hc6
`define DCPR_CNT_P6 8'hca
`define DCPR_CNT_P7 8'hce
`define DCPR_PG_P0 8'h87
`define DCPR_PG_P1 8'h83
`define DCPR_PG_P2 8'h81
`define DCPR_PG_P3 8'h82
`define DCPR_PG_P4 8'h8f
`define DCPR_PG_P5 8'h8b
`define DCPR_PG_P6 8'h89
`define DCPR_PG_P7 8'h8a
`define DCPR_CBP_LO 8'h0c
`define DCPR_MCLR_LO 8'h0d
`define DCPR_CMSK_LO 8'h0e
`define DCPR_CBP_HI 8'hd8
`define DCPR_MCLR_HI 8'hda
`define DCPR_CMSK_HI 8'hdc
// ==========================================
// values and layout
`define DCPR_CH_PER_CTL 4
`define DCPR_CNT_WRAP 16'hffff
`define DCPR_RD_IDLE 8'h00
`define DCPR_MASK_SET 4'hf
`define DCPR_AW 24
`endif

/* verilog/dcpr_pkg.sv */
`default_nettype none
package dcpr_pkg;
    typedef logic [7:0][15:0] dcpr_word_t;
    typedef struct packed {
        dcpr_word_t base_cnt;
        dcpr_word_t cur_cnt;
        dcpr_word_t base_adr;
        dcpr_word_t cur_adr;
        logic [7:0][7:0] page;
        logic [1:0] bptr;
        logic [7:0] mask;
        logic [7:0] tc_pulse;
        logic [7:0] rdata;
    } dcpr_state_s;
endpackage : dcpr_pkg
`default_nettype wire

/* verilog/dcpr_top.sv */
// Notes on behaviour
// R1 - transfers done equal programmed count plus one
// R2 - count_exhausted when count wraps zero to ffff
// R3 - autoinitialize happens only at count_exhausted
// R4 - without autoinit count holds ffff afterwards
// R5 - channels 0-3 count bytes
// R6 - channels 4-7 count words, shifted address
// R7 - 16-bit base/current count, read and write
// R8 - page register supplies address bits 23:16 (ch 4-7: page bits 7:1 give 23:17)
// R9 - page unchanged by autoinitialize
// R10 - clear byte pointer port resets pointer
// R11 - pointer alternates low then high byte
// R12 - reset and master clear clear pointer
// R13 - software clears pointer before new values
// R14 - master clear port acts like reset
// R15 - clear mask port unmasks four channels
// R16 - command ports write-only, data ignored
// R17 - count and page undefined after clear
// R18 - address steps after each transfer
// R19 - count decrements after each transfer
// R20 - autoinit reloads current from base
`include "dcpr_consts.svh"
`default_nettype none
module dcpr_top import dcpr_pkg::*; (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic [7:0] xfer_done,
    input wire logic [7:0] autoinit_en,
    input wire logic [7:0] addr_down,
    output logic [191:0] chan_addr,
    output logic [7:0] count_exhausted,
    output logic [7:0] chan_mask,
    output logic [1:0] byte_ptr
);
    // ==========================================
    // port tables
    localparam logic [7:0][7:0] ADR_P = {`DCPR_ADR_P7, `DCPR_ADR_P6,
        `DCPR_ADR_P5, `DCPR_ADR_P4, `DCPR_ADR_P3, `DCPR_ADR_P2,
        `DCPR_ADR_P1, `DCPR_ADR_P0};
    localparam logic [7:0][7:0] CNT_P = {`DCPR_CNT_P7, `DCPR_CNT_P6,
        `DCPR_CNT_P5, `DCPR_CNT_P4, `DCPR_CNT_P3, `DCPR_CNT_P2,
        `DCPR_CNT_P1, `DCPR_CNT_P0};
    localparam logic [7:0][7:0] PG_P = {`DCPR_PG_P7, `DCPR_PG_P6,
        `DCPR_PG_P5, `DCPR_PG_P4, `DCPR_PG_P3, `DCPR_PG_P2,
        `DCPR_PG_P1, `DCPR_PG_P0};

    dcpr_state_s st_reg;
    dcpr_state_s st_next;

    // ==========================================
    // next state
    always_comb begin
        logic hi_ok;
        logic [7:0] lo;
        logic [1:0] tog;
        logic [1:0] cbp;
        logic [1:0] mclr;
        logic [1:0] cmsk;
        logic ctl;
        logic sel;
        hi_ok = (io_addr[15:8] == `DCPR_IO_HI);
        lo = io_addr[7:0];
        tog = 2'h0;
        ctl = 1'b0;
        sel = 1'b0;
        // any data value triggers a command
        cbp[0] = io_wr && hi_ok && lo == `DCPR_CBP_LO; // R16
        cbp[1] = io_wr && hi_ok && lo == `DCPR_CBP_HI;
        mclr[0] = io_wr && hi_ok && lo == `DCPR_MCLR_LO;
        mclr[1] = io_wr && hi_ok && lo == `DCPR_MCLR_HI;
        cmsk[0] = io_wr && hi_ok && lo == `DCPR_CMSK_LO;
        cmsk[1] = io_wr && hi_ok && lo == `DCPR_CMSK_HI;
        st_next = st_reg;
        st_next.tc_pulse = 8'h00;
        if (io_rd) begin
            st_next.rdata = `DCPR_RD_IDLE;
        end
        for (int ch = 0; ch < 8; ch++) begin
            ctl = (ch >= `DCPR_CH_PER_CTL);
            sel = st_reg.bptr[ctl];
            // one step per byte (ch 0-3) or word (ch 4-7); R5 R6
            if (xfer_done[ch]) begin
                if (st_reg.cur_cnt[ch] == 16'h0000) begin
                    st_next.tc_pulse[ch] = 1'b1; // R2 R1
                    if (autoinit_en[ch]) begin
                        // page is left alone here; R9
                        st_next.cur_cnt[ch] = st_reg.base_cnt[ch]; // R3 R20
                        st_next.cur_adr[ch] = st_reg.base_adr[ch]; // R20
                    end else begin
                        st_next.cur_cnt[ch] = `DCPR_CNT_WRAP; // R4
                    end
                end else begin
                    st_next.cur_cnt[ch] = st_reg.cur_cnt[ch] - 16'h0001; // R19
                end
                if (!(st_reg.cur_cnt[ch] == 16'h0000 && autoinit_en[ch]))
                begin
                    if (addr_down[ch]) begin
                        st_next.cur_adr[ch] = st_reg.cur_adr[ch] - 16'h0001;
                    end else begin
                        st_next.cur_adr[ch] = st_reg.cur_adr[ch] + 16'h0001;
                    end // R18
                end
            end
            // in one cycle a software write wins over a transfer step for the byte it writes; the other byte keeps the step
            if (hi_ok && lo == CNT_P[ch] && (io_rd || io_wr)) begin
                tog[ctl] = 1'b1; // R11
                if (io_rd) begin
                    st_next.rdata = sel ? st_reg.cur_cnt[ch][15:8]
                                        : st_reg.cur_cnt[ch][7:0]; // R7
                end
                if (io_wr && sel) begin
                    st_next.base_cnt[ch][15:8] = io_wdata; // R7
                    st_next.cur_cnt[ch][15:8] = io_wdata;
                end else if (io_wr) begin
                    st_next.base_cnt[ch][7:0] = io_wdata;
                    st_next.cur_cnt[ch][7:0] = io_wdata;
                end
            end
            if (hi_ok && lo == ADR_P[ch] && (io_rd || io_wr)) begin
                tog[ctl] = 1'b1; // R11
                if (io_rd) begin
                    st_next.rdata = sel ? st_reg.cur_adr[ch][15:8]
                                        : st_reg.cur_adr[ch][7:0];
                end
                if (io_wr && sel) begin
                    st_next.base_adr[ch][15:8] = io_wdata;
                    st_next.cur_adr[ch][15:8] = io_wdata;
                end else if (io_wr) begin
                    st_next.base_adr[ch][7:0] = io_wdata;
                    st_next.cur_adr[ch][7:0] = io_wdata;
                end
            end
            if (hi_ok && lo == PG_P[ch]) begin
                if (io_rd) begin
                    st_next.rdata = st_reg.page[ch]; // R8
                end
                if (io_wr) begin
                    st_next.page[ch] = io_wdata;
                end
            end
        end
        for (int c = 0; c < 2; c++) begin
            if (tog[c]) begin
                st_next.bptr[c] = ~st_reg.bptr[c]; // R11
            end
            if (cbp[c] || mclr[c]) begin
                // counts and pages stay as they are; R17
                st_next.bptr[c] = 1'b0; // R10 R12 R14
            end
            if (cmsk[c]) begin
                st_next.mask[c*4 +: 4] = 4'h0; // R15
            end
            if (mclr[c]) begin
                st_next.mask[c*4 +: 4] = `DCPR_MASK_SET; // R14
            end
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            // counts/pages are nominally undefined; zero keeps sim clean
            st_reg <= '0;
            st_reg.mask <= {`DCPR_MASK_SET, `DCPR_MASK_SET}; // R12
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================
    // outputs
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_addr
            if (g < `DCPR_CH_PER_CTL) begin : g_byte
                assign chan_addr[g*`DCPR_AW +: `DCPR_AW] =
                    {st_reg.page[g], st_reg.cur_adr[g]}; // R8
            end else begin : g_word
                // word channels: bit 0 of the page is not used; R6
                assign chan_addr[g*`DCPR_AW +: `DCPR_AW] =
                    {st_reg.page[g][7:1], st_reg.cur_adr[g], 1'b0}; // R8
            end
        end
    endgenerate

    assign io_rdata = st_reg.rdata;
    assign count_exhausted = st_reg.tc_pulse;
    assign chan_mask = st_reg.mask;
    assign byte_ptr = st_reg.bptr;

    // ==========================================
    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    logic quiet;
    assign quiet = !io_wr && !io_rd;

    property p_count_dec;
        xfer_done[0] && quiet && st_reg.cur_cnt[0] != 16'h0000
        |=> st_reg.cur_cnt[0] == $past(st_reg.cur_cnt[0]) - 16'h0001;
    endproperty
    a_count_dec: assert property (p_count_dec) // R19 R1 R7
        else $error("count did not step down by one");

    property p_tc_zero;
        1'b1 |=> count_exhausted[0] ==
            $past(xfer_done[0] && st_reg.cur_cnt[0] == 16'h0000);
    endproperty
    a_tc_zero: assert property (p_tc_zero) // R2
        else $error("count_exhausted not tied to zero wrap");

    property p_hold_wrap;
        xfer_done[0] && !autoinit_en[0] && quiet &&
        st_reg.cur_cnt[0] == 16'h0000
        |=> st_reg.cur_cnt[0] == 16'hffff ##1
            (!xfer_done[0] && quiet) [*2] |-> st_reg.cur_cnt[0] == 16'hffff;
    endproperty
    a_hold_wrap: assert property (p_hold_wrap) // R4
        else $error("count not ffff after exhaustion");

    property p_reload;
        xfer_done[5] && autoinit_en[5] && quiet &&
        st_reg.cur_cnt[5] == 16'h0000
        |=> st_reg.cur_cnt[5] == $past(st_reg.base_cnt[5]) &&
            st_reg.cur_adr[5] == $past(st_reg.base_adr[5]);
    endproperty
    a_reload: assert property (p_reload) // R20 R3
        else $error("autoinit did not reload from base");

    property p_only_on_tc;
        !xfer_done[0] && quiet |=> $stable(st_reg.cur_cnt[0]) &&
            $stable(st_reg.cur_adr[0]);
    endproperty
    a_only_on_tc: assert property (p_only_on_tc) // R3
        else $error("count changed without a transfer");

    property p_page_kept;
        !io_wr |=> $stable(chan_addr[23:16]);
    endproperty
    a_page_kept: assert property (p_page_kept) // R9 R8
        else $error("page moved without a write");

    property p_addr_up;
        xfer_done[0] && !addr_down[0] && quiet &&
        st_reg.cur_cnt[0] != 16'h0000
        |=> chan_addr[15:0] == $past(chan_addr[15:0]) + 16'h0001;
    endproperty
    a_addr_up: assert property (p_addr_up) // R18 R5
        else $error("byte channel address did not step");

    property p_word_step;
        xfer_done[5] && addr_down[5] && quiet &&
        st_reg.cur_cnt[5] != 16'h0000
        |=> chan_addr[5*24 +: 17] == $past(chan_addr[5*24 +: 17]) - 17'h2;
    endproperty
    a_word_step: assert property (p_word_step) // R6
        else $error("word channel address did not step by two");

    property p_cbp;
        io_wr && io_addr == {`DCPR_IO_HI, `DCPR_CBP_LO}
        |=> byte_ptr[0] == 1'b0;
    endproperty
    a_cbp: assert property (p_cbp) // R10 R16
        else $error("byte pointer not cleared");

    property p_toggle;
        io_wr && io_addr == {`DCPR_IO_HI, `DCPR_CNT_P0}
        |=> byte_ptr[0] != $past(byte_ptr[0]);
    endproperty
    a_toggle: assert property (p_toggle) // R11
        else $error("byte pointer did not alternate");

    property p_mclr;
        io_wr && io_addr == {`DCPR_IO_HI, `DCPR_MCLR_HI}
        |=> byte_ptr[1] == 1'b0 && chan_mask[7:4] == 4'hf;
    endproperty
    a_mclr: assert property (p_mclr) // R14 R12
        else $error("master clear did not act as reset");

    property p_cmsk;
        io_wr && io_addr == {`DCPR_IO_HI, `DCPR_CMSK_LO}
        |=> chan_mask[3:0] == 4'h0 && $stable(chan_mask[7:4]);
    endproperty
    a_cmsk: assert property (p_cmsk) // R15
        else $error("clear mask did not unmask channels");

    property p_cbp_hi;
        io_wr && io_addr == {`DCPR_IO_HI, `DCPR_CBP_HI}
        |=> byte_ptr[1] == 1'b0;
    endproperty
    a_cbp_hi: assert property (p_cbp_hi) // R10
        else $error("high byte pointer not cleared");

    property p_cmsk_hi;
        io_wr && io_addr == {`DCPR_IO_HI, `DCPR_CMSK_HI}
        |=> chan_mask[7:4] == 4'h0 && $stable(chan_mask[3:0]);
    endproperty
    a_cmsk_hi: assert property (p_cmsk_hi) // R15
        else $error("clear mask did not unmask high channels");

    property p_tc_word;
        1'b1 |=> count_exhausted[5] ==
            $past(xfer_done[5] && st_reg.cur_cnt[5] == 16'h0000);
    endproperty
    a_tc_word: assert property (p_tc_word) // R2 R6
        else $error("word channel exhaustion not tied to zero wrap");

    property p_page_rd;
        io_rd && io_addr == {`DCPR_IO_HI, `DCPR_PG_P5}
        |=> io_rdata == $past(st_reg.page[5]);
    endproperty
    a_page_rd: assert property (p_page_rd) // R8
        else $error("page read back wrong");

    property p_cnt_lo_wr;
        io_wr && io_addr == {`DCPR_IO_HI, `DCPR_CNT_P0} && !byte_ptr[0]
        |=> st_reg.base_cnt[0][7:0] == $past(io_wdata);
    endproperty
    a_cnt_lo_wr: assert property (p_cnt_lo_wr) // R7 R11
        else $error("low count byte not written");

    property p_c_tc;
        count_exhausted[0];
    endproperty
    c_tc: cover property (p_c_tc);

    property p_c_init;
        xfer_done[5] && autoinit_en[5] && st_reg.cur_cnt[5] == 16'h0000;
    endproperty
    c_init: cover property (p_c_init);

    property p_c_two_bytes;
        io_wr && io_addr == {`DCPR_IO_HI, `DCPR_CNT_P5} ##2
        io_wr && io_addr == {`DCPR_IO_HI, `DCPR_CNT_P5};
    endproperty
    c_two_bytes: cover property (p_c_two_bytes);
endmodule : dcpr_top
`default_nettype wire

/* test/dcpr_host_model.sv */
`default_nettype none
module dcpr_host_model (
    input wire logic clk_sys,
    output var logic [15:0] io_addr,
    output var logic io_wr,
    output var logic io_rd,
    output var logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // single byte port cycles
    initial begin
        io_addr = 16'hffff;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    // released lines invert, so stale values never look valid
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk_sys);
        io_wr <= 1'b0;
        io_addr <= ~a;
        io_wdata <= ~d;
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk_sys);
        io_rd <= 1'b0;
        io_addr <= ~a;
        @(posedge clk_sys);
        d = io_rdata;
        #1;
    endtask : rd
    // ==========================================
    // 16-bit registers, pointer cleared first
    task automatic wr16(input logic [15:0] cbp, input logic [15:0] a,
                        input logic [15:0] v);
        wr(cbp, 8'h00);
        wr(a, v[7:0]);
        wr(a, v[15:8]);
    endtask : wr16
    task automatic rd16(input logic [15:0] cbp, input logic [15:0] a,
                        output logic [15:0] v);
        wr(cbp, 8'h00);
        rd(a, v[7:0]);
        rd(a, v[15:8]);
    endtask : rd16
endmodule : dcpr_host_model
`default_nettype wire

/* test/dcpr_top_tb.sv */
`default_nettype none
module dcpr_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // signals
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] xfer_done = 8'h00;
    logic [7:0] autoinit_en = 8'h00;
    logic [7:0] addr_down = 8'h00;
    wire logic [15:0] io_addr;
    wire logic io_wr;
    wire logic io_rd;
    wire logic [7:0] io_wdata;
    wire logic [7:0] io_rdata;
    wire logic [191:0] chan_addr;
    wire logic [7:0] count_exhausted;
    wire logic [7:0] chan_mask;
    wire logic [1:0] byte_ptr;
    logic [15:0] v;
    int n_fail = 0;
    int samples_checked = 0;
    always #10 clk_sys = ~clk_sys;
    dcpr_host_model host (.clk_sys(clk_sys), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata));
    dcpr_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .xfer_done(xfer_done),
        .autoinit_en(autoinit_en), .addr_down(addr_down),
        .chan_addr(chan_addr), .count_exhausted(count_exhausted),
        .chan_mask(chan_mask), .byte_ptr(byte_ptr));
    // ==========================================
    // helpers
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    // one transfer, exhaustion pulse looked at in its only cycle
    task automatic xfer(input int ch, input logic ex);
        @(posedge clk_sys);
        xfer_done <= 8'h01 << ch;
        @(posedge clk_sys);
        xfer_done <= 8'h00;
        #1;
        chk({16'h0000, count_exhausted}, ex ? 24'h1 << ch : 24'h0);
    endtask : xfer
    // ==========================================
    // scenarios
    task automatic t_byte_count;
        host.wr16(16'h000c, 16'h0000, 16'h1000);
        host.wr(16'h0087, 8'h3c);
        host.wr16(16'h000c, 16'h0001, 16'h0002);
        host.rd16(16'h000c, 16'h0001, v);
        chk({8'h00, v}, 24'h000002);
        chk(chan_addr[23:0], 24'h3c1000);
        xfer(0, 1'b0);
        xfer(0, 1'b0);
        xfer(0, 1'b1);
        @(posedge clk_sys);
        #1;
        chk({16'h0000, count_exhausted}, 24'h0);
        chk(chan_addr[23:0], 24'h3c1003);
        host.rd16(16'h000c, 16'h0001, v);
        chk({8'h00, v}, 24'h00ffff);
    endtask : t_byte_count
    task automatic t_word_autoinit;
        @(posedge clk_sys);
        autoinit_en <= 8'h20;
        addr_down <= 8'h20;
        host.wr16(16'h00d8, 16'h00c4, 16'h2000);
        host.wr(16'h008b, 8'h56);
        host.wr16(16'h00d8, 16'h00c6, 16'h0001);
        chk(chan_addr[143:120], 24'h564000);
        xfer(5, 1'b0);
        chk(chan_addr[143:120], 24'h563ffe);
        xfer(5, 1'b1);
        chk(chan_addr[143:120], 24'h564000);
        host.rd16(16'h00d8, 16'h00c6, v);
        chk({8'h00, v}, 24'h000001);
        host.rd(16'h008b, v[7:0]);
        chk({16'h0000, v[7:0]}, 24'h000056);
    endtask : t_word_autoinit
    // odd pointers and stray data prove commands ignore the value
    task automatic t_commands;
        host.wr(16'h00dc, 8'hc3);
        chk({16'h0000, chan_mask}, 24'h00000f);
        host.wr(16'h00c6, 8'h11);
        chk({22'h0, byte_ptr}, 24'h2);
        host.wr(16'h00da, 8'h5a);
        chk({16'h0000, chan_mask}, 24'h0000ff);
        chk({22'h0, byte_ptr}, 24'h0);
        host.wr(16'h0001, 8'h77);
        chk({22'h0, byte_ptr}, 24'h1);
        host.wr(16'h000c, 8'ha5);
        chk({22'h0, byte_ptr}, 24'h0);
        host.rd(16'h00dc, v[7:0]);
        chk({16'h0000, v[7:0]}, 24'h0);
        host.rd(16'h0101, v[7:0]);
        chk({16'h0000, v[7:0]}, 24'h0);
        chk({22'h0, byte_ptr}, 24'h0);
        host.wr(16'h000e, 8'h3c);
        chk({16'h0000, chan_mask}, 24'h0000f0);
    endtask : t_commands
    // reset in mid-run with the high pointer left odd
    task automatic t_reset_mid;
        host.wr(16'h00c6, 8'h00);
        chk({22'h0, byte_ptr}, 24'h2);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk({14'h0, chan_mask, byte_ptr}, 24'h0003fc);
        @(posedge clk_sys);
        reset_n <= 1'b1;
        host.wr(16'h00dc, 8'h00);
        chk({16'h0000, chan_mask}, 24'h00000f);
    endtask : t_reset_mid
    // ==========================================
    // sequence and watchdog
    initial begin
        repeat (10) @(posedge clk_sys);
        chk({14'h0, chan_mask, byte_ptr}, 24'h0003fc);
        reset_n <= 1'b1;
        t_byte_count();
        t_word_autoinit();
        t_commands();
        t_reset_mid();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        $display("ERROR %0t: run did not finish", $time);
        end_of_test();
    end
endmodule : dcpr_top_tb
`default_nettype wire
